// >>> common/pci_cfg_map.svh
`ifndef PCI_CFG_MAP_SVH
`define PCI_CFG_MAP_SVH
// ==========================================================
// Configuration space offsets (byte addresses)
`define OFF_VENDOR_DEVICE  8'h00
`define OFF_COMMAND        8'h04
`define OFF_CLASS_REVISION 8'h08
`define OFF_BAR0           8'h10
`define OFF_BAR2           8'h18
`define OFF_BAR3           8'h1c
`define OFF_SUBSYSTEM      8'h2c
`define OFF_ROM_BAR        8'h30
`define OFF_MAP_FIRST      8'h44
`define OFF_MAP_LAST       8'h80
`define OFF_SUBSYS_OVR     8'h8c
`define OFF_INTA_ASSERT    8'h90
`define OFF_VENDOR_OVR     8'h9c
`define OFF_CLASS_OVR      8'ha0
`define OFF_DEVICE_CTRL    8'ha4
// ==========================================================
// Field positions and values
`define HOLD_BIT           0
`define INTA_BIT           0
`define HOLD_RESET         1'b1
`define OVR_RESET          32'h0000_0000
`define COMMAND_MASK       32'h0000_0007
`define BAR0_MASK          32'hff00_0000
`define BAR23_MASK         32'hffff_f000
`define ROM_MASK           32'hffff_0001
`define OVERRIDE_MIN_REV   8'h03
`endif

// >>> common/pci_cfg_pkg.sv
// ==========================================================
// Types shared by the configuration gate
package pci_cfg_pkg;
   // One configuration access
   typedef struct packed {
      logic        we;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } cfg_req_s;
   // Access view of the register space
   typedef enum logic [1:0] {
      VIEW_HOST  = 2'b00,
      VIEW_SETUP = 2'b01,
      VIEW_RUN   = 2'b11
   } cfg_view_e;
endpackage

// >>> logic/map_table_mem.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Translation table storage, registered read
module map_table_mem #(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [31:0]   wdata,
   // Read port
   input  wire logic [AW-1:0] raddr,
   output logic      [31:0]   rdata
);
   logic [31:0] mem [DEPTH];

   // Storage write
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

// >>> logic/bar_regs.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Base address registers, one per window
module bar_regs #(
   parameter int              N     = 4,
   parameter logic [N*32-1:0] MASKS = '0
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // Write side
   input  wire logic            we,
   input  wire logic [N-1:0]    sel,
   input  wire logic [31:0]     wdata,
   // Programmed bases
   output logic      [N*32-1:0] bases
);
   // Writable bits only, size bits stay zero
   for (genvar i = 0; i < N; i++) begin : g_bar
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            bases[i*32 +: 32] <= 32'h0000_0000;
         end else if (we && sel[i]) begin
            bases[i*32 +: 32] <= wdata & MASKS[i*32 +: 32];
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/pci_device_mode_config_gate.sv
// Overview of operation
// - Device answers BAR0, BAR2, BAR3, ROM; BAR0 uses map table, BAR2/3 mailboxes.
// - Map, identity overrides and interrupt bit are written only from internal bus.
// - PCI writes to map table are taken but dropped; PCI reads return junk.
// - BAR0 always shows the host a 16 MByte region needing allocation.
// - Subsystem override value is what the host reads as subsystem ids.
// - From revision 3, host sees ids taken from the local override registers.
// - Interrupt bit set drives the PCI interrupt pin low.
// - PCI reset pin driven only in host mode.
// - Hold bit resets set, opening setup access to the internal bus.
// - With hold set in device mode every PCI access is retried.
// - Dummy read after clearing hold completes normally with junk data.
// - With hold clear, internal writes to map, subsystem, interrupt still apply.
// - With hold clear, internal reads of configuration registers return junk.
// - Hold may be set again to read back; PCI reads retried meanwhile.
// - Host mode: map, overrides, interrupt read and write internally; ids read-only.
`timescale 1ns/1ns
`default_nettype none
`include "pci_cfg_map.svh"
module pci_device_mode_config_gate #(
   parameter logic [7:0]  IF_REVISION  = 8'h03,
   parameter logic [31:0] DEF_VEND_DEV = 32'h1234_5678, // Arbitrary value
   parameter logic [31:0] DEF_CLASS_RV = 32'h0b80_0001  // Arbitrary value
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Mode strap, high for host mode
   input  wire logic                 host_mode,
   // Internal bus configuration port
   input  wire logic                 ib_valid,
   input  wire pci_cfg_pkg::cfg_req_s ib_req,
   output logic                      ib_ack,
   output logic      [31:0]          ib_rdata,
   // PCI Type 0 configuration port
   input  wire logic                 pci_valid,
   input  wire pci_cfg_pkg::cfg_req_s pci_req,
   output logic                      pci_ack,
   output logic                      pci_retry,
   output logic      [31:0]          pci_rdata,
   // Programmed windows
   output logic      [31:0]          bar0_base,
   output logic      [31:0]          bar2_base,
   output logic      [31:0]          bar3_base,
   output logic      [31:0]          rom_base,
   output logic      [2:0]           command_en,
   // Interrupt pin, open drain
   input  wire logic                 pci_interrupt_pin_n_in,
   output logic                      pci_interrupt_pin_n_out,
   output logic                      pci_interrupt_pin_n_oe,
   // PCI reset pin
   output logic                      pci_reset_n_out,
   output logic                      pci_reset_n_oe
);
   // ==========================================================
   // State
   logic        hold;
   logic [31:0] subsys_ovr;
   logic [31:0] vendor_ovr;
   logic [31:0] class_ovr;
   logic        inta_set;
   logic [31:0] command;
   logic [127:0] bases;
   logic [31:0] map_rdata;
   logic        ib_map_q;
   logic [31:0] ib_data_q;
   pci_cfg_pkg::cfg_view_e view;

   // ==========================================================
   // Access view
   assign view = host_mode ? pci_cfg_pkg::VIEW_HOST :
                 hold      ? pci_cfg_pkg::VIEW_SETUP :
                             pci_cfg_pkg::VIEW_RUN;

   // Address decode, internal side
   wire [7:0] ia      = ib_req.addr;
   wire ib_map_hit    = ia >= `OFF_MAP_FIRST && ia <= `OFF_MAP_LAST;
   wire ib_prot       = ib_map_hit || ia == `OFF_SUBSYS_OVR ||
                        ia == `OFF_INTA_ASSERT || ia == `OFF_VENDOR_OVR ||
                        ia == `OFF_CLASS_OVR;
   wire ib_ident      = ia == `OFF_VENDOR_DEVICE || ia == `OFF_CLASS_REVISION;
   wire ib_wr         = ib_valid && ib_req.we;
   wire ib_rd         = ib_valid && !ib_req.we;

   // Address decode, PCI side
   wire [7:0] pa      = pci_req.addr;
   wire pci_map_hit   = pa >= `OFF_MAP_FIRST && pa <= `OFF_MAP_LAST;
   wire pci_prot      = pci_map_hit || pa == `OFF_SUBSYS_OVR ||
                        pa == `OFF_INTA_ASSERT || pa == `OFF_VENDOR_OVR ||
                        pa == `OFF_CLASS_OVR || pa == `OFF_DEVICE_CTRL;
   wire pci_ident     = pa == `OFF_VENDOR_DEVICE || pa == `OFF_CLASS_REVISION;
   wire pci_run       = pci_valid && view == pci_cfg_pkg::VIEW_RUN;
   wire pci_retry_now = pci_valid && view == pci_cfg_pkg::VIEW_SETUP;

   // Internal writes to protected registers apply in every view
   wire prot_we       = ib_wr && ib_prot;
   wire map_we        = prot_we && ib_map_hit;
   wire [3:0] map_widx = 4'((ia - `OFF_MAP_FIRST) >> 2);

   // Standard registers: PCI in run view, internal only in host view
   wire std_we_pci    = pci_run && pci_req.we && !pci_prot && !pci_ident;
   wire std_we_ib     = ib_wr && !ib_prot && !ib_ident &&
                        view == pci_cfg_pkg::VIEW_HOST;
   wire std_we        = std_we_pci || std_we_ib;
   wire [7:0] std_a   = std_we_pci ? pa : ia;
   wire [31:0] std_d  = std_we_pci ? pci_req.wdata : ib_req.wdata;
   wire [3:0] bar_sel = {std_a == `OFF_ROM_BAR, std_a == `OFF_BAR3,
                         std_a == `OFF_BAR2, std_a == `OFF_BAR0};

   // Identity seen by the host
   wire new_ids       = IF_REVISION >= `OVERRIDE_MIN_REV;
   wire [31:0] vd_id  = new_ids ? vendor_ovr : DEF_VEND_DEV;
   wire [31:0] cr_id  = new_ids ? class_ovr : DEF_CLASS_RV;

   // Standard register readout shared by both sides
   function automatic logic [31:0] std_read(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         `OFF_VENDOR_DEVICE:  v = vd_id;
         `OFF_CLASS_REVISION: v = cr_id;
         `OFF_COMMAND:        v = command;
         `OFF_BAR0:           v = bases[31:0];
         `OFF_BAR2:           v = bases[63:32];
         `OFF_BAR3:           v = bases[95:64];
         `OFF_ROM_BAR:        v = bases[127:96];
         `OFF_SUBSYSTEM:      v = subsys_ovr;
         default:             v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Internal read value for non-table registers
   wire [31:0] prot_val = ia == `OFF_SUBSYS_OVR  ? subsys_ovr :
                          ia == `OFF_INTA_ASSERT ? {31'h0, inta_set} :
                          ia == `OFF_VENDOR_OVR  ? vendor_ovr :
                          ia == `OFF_CLASS_OVR   ? class_ovr : 32'h0000_0000;
   wire ib_std_ok       = view == pci_cfg_pkg::VIEW_HOST ||
                          (view == pci_cfg_pkg::VIEW_SETUP && ib_ident);
   wire [31:0] next_ib_data = view == pci_cfg_pkg::VIEW_RUN ? 32'h0000_0000 :
                          ib_prot   ? prot_val :
                          ib_std_ok ? std_read(ia) : 32'h0000_0000;
   wire ib_map_rd       = ib_rd && ib_map_hit && view != pci_cfg_pkg::VIEW_RUN;

   // PCI read value: protected registers read as zero
   wire [31:0] next_pci_data = pci_prot ? 32'h0000_0000 : std_read(pa);

   // ==========================================================
   // Translation table
   map_table_mem #(.DEPTH(16), .AW(4)) u_map (
      .clk   (clk),
      .rst   (rst),
      .we    (map_we),
      .waddr (map_widx),
      .wdata (ib_req.wdata),
      .raddr (map_widx),
      .rdata (map_rdata)
   );

   // Windows, BAR0 fixed at 16 MByte
   bar_regs #(
      .N     (4),
      .MASKS ({`ROM_MASK, `BAR23_MASK, `BAR23_MASK, `BAR0_MASK})
   ) u_bars (
      .clk   (clk),
      .rst   (rst),
      .we    (std_we),
      .sel   (bar_sel),
      .wdata (std_d),
      .bases (bases)
   );

   // Window outputs for the address decoders
   assign bar0_base  = bases[31:0];
   assign bar2_base  = bases[63:32];
   assign bar3_base  = bases[95:64];
   assign rom_base   = bases[127:96];
   assign command_en = command[2:0];

   // ==========================================================
   // Hold bit, write-only, set out of reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold <= `HOLD_RESET;
      end else if (ib_wr && ia == `OFF_DEVICE_CTRL) begin
         hold <= ib_req.wdata[`HOLD_BIT];
      end
   end

   // Protected registers, internal side only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         subsys_ovr <= `OVR_RESET;
         vendor_ovr <= `OVR_RESET;
         class_ovr  <= `OVR_RESET;
         inta_set   <= 1'b0;
      end else if (prot_we) begin
         if (ia == `OFF_SUBSYS_OVR)  subsys_ovr <= ib_req.wdata;
         if (ia == `OFF_VENDOR_OVR)  vendor_ovr <= ib_req.wdata;
         if (ia == `OFF_CLASS_OVR)   class_ovr  <= ib_req.wdata;
         if (ia == `OFF_INTA_ASSERT) inta_set   <= ib_req.wdata[`INTA_BIT];
      end
   end

   // Command register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         command <= 32'h0000_0000;
      end else if (std_we && std_a == `OFF_COMMAND) begin
         command <= std_d & `COMMAND_MASK;
      end
   end

   // Internal side answer, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ib_ack    <= 1'b0;
         ib_map_q  <= 1'b0;
         ib_data_q <= 32'h0000_0000;
      end else begin
         ib_ack    <= ib_valid;
         ib_map_q  <= ib_map_rd;
         ib_data_q <= next_ib_data;
      end
   end
   assign ib_rdata = ib_map_q ? map_rdata : ib_data_q;

   // PCI side answer: retry in setup, complete otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pci_ack   <= 1'b0;
         pci_retry <= 1'b0;
         pci_rdata <= 32'h0000_0000;
      end else begin
         pci_ack   <= pci_valid && !pci_retry_now;
         pci_retry <= pci_retry_now;
         pci_rdata <= pci_run && !pci_req.we ? next_pci_data : 32'h0000_0000;
      end
   end

   // Pins
   assign pci_interrupt_pin_n_out = 1'b0;
   assign pci_interrupt_pin_n_oe  = inta_set;
   assign pci_reset_n_out         = 1'b1;
   assign pci_reset_n_oe          = host_mode;

   // ==========================================================
   // Assertions
   logic       pci_rd_q;
   logic [7:0] pci_a_q;
   logic [7:0] ib_a_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pci_rd_q <= 1'b0;
         pci_a_q  <= 8'h00;
         ib_a_q   <= 8'h00;
      end else begin
         pci_rd_q <= pci_run && !pci_req.we;
         pci_a_q  <= pa;
         ib_a_q   <= ia;
      end
   end

   property p_hold_reset;
      @(posedge clk) $fell(rst) |-> hold && view != pci_cfg_pkg::VIEW_RUN;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("hold not set after reset");

   property p_retry;
      @(posedge clk) disable iff (rst)
         pci_valid && !host_mode && hold |=> pci_retry && !pci_ack;
   endproperty
   a_retry: assert property (p_retry) else $error("setup access not retried");

   property p_no_pci_map_write;
      @(posedge clk) disable iff (rst) map_we |-> ib_valid && ib_req.we;
   endproperty
   a_no_pci_map_write: assert property (p_no_pci_map_write) else $error("map written by pci");

   property p_bar0_size;
      @(posedge clk) disable iff (rst)
         pci_rd_q && pci_a_q == `OFF_BAR0 |-> pci_rdata[23:0] == 24'h000000;
   endproperty
   a_bar0_size: assert property (p_bar0_size) else $error("bar0 size wrong");

   property p_subsys_read;
      @(posedge clk) disable iff (rst)
         pci_run && !pci_req.we && pa == `OFF_SUBSYSTEM ##1 !ib_valid[*1]
         |-> pci_rdata == $past(subsys_ovr);
   endproperty
   a_subsys_read: assert property (p_subsys_read) else $error("subsystem id mismatch");

   property p_ident_ovr;
      @(posedge clk) disable iff (rst)
         new_ids && pci_rd_q && pci_a_q == `OFF_VENDOR_DEVICE |-> pci_rdata == $past(vendor_ovr);
   endproperty
   a_ident_ovr: assert property (p_ident_ovr) else $error("vendor id not overridden");

   property p_inta;
      @(posedge clk) disable iff (rst)
         $rose(inta_set) |-> pci_interrupt_pin_n_oe && !pci_interrupt_pin_n_out;
   endproperty
   a_inta: assert property (p_inta) else $error("interrupt pin not driven");

   property p_reset_pin;
      @(posedge clk) disable iff (rst) !host_mode |-> !pci_reset_n_oe;
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin driven in device mode");

   property p_subsys_write;
      @(posedge clk) disable iff (rst)
         ib_wr && ia == `OFF_SUBSYS_OVR |=> subsys_ovr == $past(ib_req.wdata);
   endproperty
   a_subsys_write: assert property (p_subsys_write) else $error("subsystem write lost");

   property p_run_read;
      @(posedge clk) disable iff (rst)
         ib_rd && view == pci_cfg_pkg::VIEW_RUN |=> ib_ack && ib_rdata == 32'h0000_0000;
   endproperty
   a_run_read: assert property (p_run_read) else $error("run read not flat");

   property p_pci_no_ovr;
      @(posedge clk) disable iff (rst)
         !ib_valid |=> $stable(subsys_ovr) && $stable(inta_set);
   endproperty
   a_pci_no_ovr: assert property (p_pci_no_ovr) else $error("override changed by pci");

   property p_id_write_ignored;
      @(posedge clk) disable iff (rst) std_we |-> !(std_a == `OFF_VENDOR_DEVICE);
   endproperty
   a_id_write_ignored: assert property (p_id_write_ignored) else $error("id written");

   c_setup_retry: cover property (@(posedge clk) disable iff (rst) pci_retry);
   c_run_read:    cover property (@(posedge clk) disable iff (rst) pci_rd_q);
   c_hold_clear:  cover property (@(posedge clk) disable iff (rst) $fell(hold));
   c_ident_read:  cover property (@(posedge clk) disable iff (rst) ib_ack && ib_a_q == `OFF_VENDOR_DEVICE);
endmodule
`default_nettype wire

// >>> verification/pci_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// External host issuing Type 0 config cycles
module pci_host_model (
   // Clock
   input  wire logic                  clk,
   // Request side
   output logic                       pci_valid,
   output pci_cfg_pkg::cfg_req_s      pci_req,
   // Answer side
   input  wire logic                  pci_ack,
   input  wire logic                  pci_retry,
   input  wire logic [31:0]           pci_rdata
);
   // Idle request lines
   initial begin
      pci_valid = 1'b0;
      pci_req   = '0;
   end
   // One access, flags a retry or no answer
   task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic rty, output logic ok);
      int n;
      ok  = 1'b0;
      rty = 1'b0;
      q   = '0;
      @(negedge clk);
      pci_req   = '{we, a, d};
      pci_valid = 1'b1;
      @(negedge clk);
      pci_valid = 1'b0;
      pci_req   = ~pci_req; // Released lines do not keep old value
      // Answer stands for one cycle only, so look before waiting again
      for (n = 0; n < 4 && !ok; n++) begin
         if (pci_ack === 1'b1 || pci_retry === 1'b1) begin
            ok  = 1'b1;
            rty = pci_retry;
            q   = pci_rdata;
         end else begin
            @(negedge clk);
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> verification/test_pci_device_mode_config_gate.sv
`timescale 1ns/1ns
`default_nettype none
`include "pci_cfg_map.svh"
// ==========================================
// Bench for the configuration gate
module test_pci_device_mode_config_gate;
   logic                  clk;
   logic                  rst;
   logic                  host_mode;
   logic                  ib_valid;
   pci_cfg_pkg::cfg_req_s ib_req;
   logic                  ib_ack;
   logic [31:0]           ib_rdata;
   logic                  pci_valid;
   pci_cfg_pkg::cfg_req_s pci_req;
   logic                  pci_ack;
   logic                  pci_retry;
   logic [31:0]           pci_rdata;
   logic [127:0]          bases;
   logic [2:0]            command_en;
   logic                  int_out;
   logic                  int_oe;
   logic                  rst_out;
   logic                  rst_oe;
   wire                   int_pin_n = int_oe ? int_out : 1'b1; // Pulled up
   int                    mismatches = 0;
   int                    n_compared = 0;

   pci_device_mode_config_gate i_dut (
      .clk(clk), .rst(rst), .host_mode(host_mode),
      .ib_valid(ib_valid), .ib_req(ib_req), .ib_ack(ib_ack), .ib_rdata(ib_rdata),
      .pci_valid(pci_valid), .pci_req(pci_req), .pci_ack(pci_ack),
      .pci_retry(pci_retry), .pci_rdata(pci_rdata),
      .bar0_base(bases[31:0]), .bar2_base(bases[63:32]),
      .bar3_base(bases[95:64]), .rom_base(bases[127:96]), .command_en(command_en),
      .pci_interrupt_pin_n_in(int_pin_n), .pci_interrupt_pin_n_out(int_out),
      .pci_interrupt_pin_n_oe(int_oe),
      .pci_reset_n_out(rst_out), .pci_reset_n_oe(rst_oe));

   pci_host_model i_host (
      .clk(clk), .pci_valid(pci_valid), .pci_req(pci_req),
      .pci_ack(pci_ack), .pci_retry(pci_retry), .pci_rdata(pci_rdata));

   // ==========================================
   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ==========================================
   // Checking and closing
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic cmp1(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic lost(input string what);
      mismatches++;
      $display("unexpected %s: expected answer, seen none", what);
      conclude();
   endtask

   // ==========================================
   // Access tasks
   task automatic ib(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int   n;
      logic ok;
      ok = 1'b0;
      q  = '0;
      @(negedge clk);
      ib_req   = '{we, a, d};
      ib_valid = 1'b1;
      @(negedge clk);
      ib_valid = 1'b0;
      ib_req   = ~ib_req;
      // Answer stands for one cycle only, so look before waiting again
      for (n = 0; n < 4 && !ok; n++) begin
         if (ib_ack === 1'b1) begin
            ok = 1'b1;
            q  = ib_rdata;
         end else begin
            @(negedge clk);
         end
      end
      if (!ok) begin
         lost("ib ack");
      end
   endtask
   task automatic ib_wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ib(1'b1, a, d, q);
   endtask
   task automatic ib_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ib(1'b0, a, 32'h0, q);
      cmp32("ib data", exp, q);
   endtask
   task automatic pci(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic x_rty, input logic [31:0] x_q);
      logic [31:0] q;
      logic        rty;
      logic        ok;
      i_host.cfg(we, a, d, q, rty, ok);
      if (!ok) begin
         lost("pci answer");
      end
      cmp1("pci retry", x_rty, rty);
      cmp32("pci data", x_q, q);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      logic [7:0]  b_off [4];
      logic [31:0] b_exp [4];
      b_off = '{`OFF_BAR0, `OFF_BAR2, `OFF_BAR3, `OFF_ROM_BAR};
      b_exp = '{32'hff00_0000, 32'hffff_f000, 32'hffff_f000, 32'hffff_0001};
      rst       = 1'b1;
      host_mode = 1'b0;
      ib_valid  = 1'b0;
      ib_req    = '0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      // After reset the hold bit blocks the host
      cmp1("inta oe", 1'b0, int_oe);
      cmp1("reset oe", 1'b0, rst_oe);
      pci(1'b0, `OFF_VENDOR_DEVICE, 32'h0, 1'b1, 32'h0);
      pci(1'b1, `OFF_SUBSYS_OVR, 32'h5a5a_5a5a, 1'b1, 32'h0);
      ib_rd(`OFF_DEVICE_CTRL, 32'h0);
      $display("test reset done");
      // Local setup of protected registers
      ib_wr(`OFF_MAP_FIRST, 32'h0102_0304);
      ib_wr(`OFF_MAP_LAST, 32'ha5a5_5a5a);
      ib_wr(`OFF_SUBSYS_OVR, 32'h1111_2222);
      ib_wr(`OFF_VENDOR_OVR, 32'h3333_4444);
      ib_wr(`OFF_CLASS_OVR, 32'h5555_6666);
      ib_wr(`OFF_INTA_ASSERT, 32'h1);
      ib_wr(`OFF_VENDOR_DEVICE, 32'hdead_beef);
      ib_rd(`OFF_MAP_FIRST, 32'h0102_0304);
      ib_rd(`OFF_MAP_LAST, 32'ha5a5_5a5a);
      ib_rd(`OFF_SUBSYS_OVR, 32'h1111_2222);
      ib_rd(`OFF_VENDOR_DEVICE, 32'h3333_4444);
      ib_rd(`OFF_CLASS_REVISION, 32'h5555_6666);
      ib_rd(`OFF_INTA_ASSERT, 32'h1);
      cmp1("inta oe", 1'b1, int_oe);
      cmp1("inta pin", 1'b0, int_pin_n);
      ib_wr(`OFF_DEVICE_CTRL, 32'h0);
      ib_rd(`OFF_VENDOR_DEVICE, 32'h0);
      $display("test setup done");
      // Run view once the hold bit is clear
      pci(1'b0, `OFF_VENDOR_DEVICE, 32'h0, 1'b0, 32'h3333_4444);
      pci(1'b1, `OFF_VENDOR_DEVICE, 32'hffff_ffff, 1'b0, 32'h0);
      pci(1'b0, `OFF_VENDOR_DEVICE, 32'h0, 1'b0, 32'h3333_4444);
      pci(1'b0, `OFF_CLASS_REVISION, 32'h0, 1'b0, 32'h5555_6666);
      pci(1'b0, `OFF_SUBSYSTEM, 32'h0, 1'b0, 32'h1111_2222);
      pci(1'b1, `OFF_MAP_LAST, 32'h0, 1'b0, 32'h0);
      pci(1'b0, `OFF_MAP_LAST, 32'h0, 1'b0, 32'h0);
      pci(1'b1, `OFF_INTA_ASSERT, 32'h0, 1'b0, 32'h0);
      cmp1("inta oe", 1'b1, int_oe);
      pci(1'b1, `OFF_COMMAND, 32'hffff_ffff, 1'b0, 32'h0);
      pci(1'b0, `OFF_COMMAND, 32'h0, 1'b0, 32'h7);
      cmp32("command", 32'h7, {29'h0, command_en});
      for (int i = 0; i < 4; i++) begin
         pci(1'b1, b_off[i], 32'hffff_ffff, 1'b0, 32'h0);
         pci(1'b0, b_off[i], 32'h0, 1'b0, b_exp[i]);
         cmp32("base", b_exp[i], bases[i*32 +: 32]);
      end
      $display("test run view done");
      // Local writes still apply, local reads are blank
      ib_rd(`OFF_MAP_FIRST, 32'h0);
      ib_wr(`OFF_SUBSYS_OVR, 32'h7777_8888);
      pci(1'b0, `OFF_SUBSYSTEM, 32'h0, 1'b0, 32'h7777_8888);
      ib_wr(`OFF_MAP_FIRST, 32'h0bad_f00d);
      ib_wr(`OFF_INTA_ASSERT, 32'h0);
      cmp1("inta oe", 1'b0, int_oe);
      // Hold set again for read back
      ib_wr(`OFF_DEVICE_CTRL, 32'h1);
      pci(1'b0, `OFF_SUBSYSTEM, 32'h0, 1'b1, 32'h0);
      ib_rd(`OFF_MAP_FIRST, 32'h0bad_f00d);
      ib_rd(`OFF_MAP_LAST, 32'ha5a5_5a5a);
      ib_rd(`OFF_SUBSYS_OVR, 32'h7777_8888);
      $display("test read back done");
      // Host mode
      @(negedge clk);
      host_mode = 1'b1;
      @(negedge clk);
      cmp1("reset oe", 1'b1, rst_oe);
      cmp1("reset out", 1'b1, rst_out);
      pci(1'b0, `OFF_VENDOR_DEVICE, 32'h0, 1'b0, 32'h0);
      ib_wr(`OFF_VENDOR_DEVICE, 32'h0);
      ib_rd(`OFF_VENDOR_DEVICE, 32'h3333_4444);
      ib_wr(`OFF_INTA_ASSERT, 32'h1);
      ib_rd(`OFF_INTA_ASSERT, 32'h1);
      ib_wr(`OFF_MAP_LAST, 32'h1234_4321);
      ib_rd(`OFF_MAP_LAST, 32'h1234_4321);
      $display("test host mode done");
      conclude();
   end
endmodule
`default_nettype wire
